// ### rtl/drra_readout.sv
// readout register access logic and its burst fifo
`timescale 1ns/1ps
`default_nettype none
`include "drra_params.svh"

module drra_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic ready;
  } drra_fifo_s_t;
  drra_fifo_s_t s_reg, s_next;
  logic push, pop;

  // ready is a flop so the block's command ready comes straight from it
  always_comb begin
    s_next = s_reg;
    push = in_valid && s_reg.ready;
    pop = out_ready && (s_reg.count != '0);
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = s_reg.rd + 1'b1;
    end
    s_next.count = s_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_next.ready = (s_next.count != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready = s_reg.ready;
  assign out_valid = (s_reg.count != '0);
  assign out_data = s_reg.mem[s_reg.rd];
endmodule

// Function
// - reads use fixed eight or chop four
// - read inversion ignored in readout mode
// - page 0 defaults at reset, kept until rewritten
// - format field: serial, parallel, staggered
// - page select from mode bits one:zero
// - bank bits pick register within page; parallel format always reads register 0
// - A2 picks beat order in chop four only, chop tristates
// - low address bits zero, others ignored
// - burst starts at read latency after command
// - strobes toggle with data, with preamble
// - serial: same bits every lane, msb first
// - page 2 reg 1 vref and geardown
// - refresh mode field encoding in bits 4:3
// - four pages of four bytes, formats limited
// - register bit 7 goes in first beat
module drra_readout
  import drra_pkg::*;
#(
  parameter logic HARD_REPAIR_SUPPORT = 1'b0,
  parameter logic SOFT_REPAIR_SUPPORT = 1'b0,
  parameter logic SELFTEST_REPAIR_SUPPORT = 1'b0,
  parameter logic [1:0] REPAIR_TRANSPARENCY = 2'h0,
  parameter logic [3:0] ACTIVATION_COUNT_LIMIT = 4'h0 // arbitrary
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_mrs,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic [2:0] cmd_mr_sel,
  input wire logic [17:0] cmd_addr,
  input wire logic [1:0] cmd_ba,
  input wire logic [1:0] cmd_bg,
  input wire logic [6:0] read_latency,
  input wire logic [23:0] err_frame,
  input wire logic err_crc,
  input wire logic err_parity,
  input wire logic [2:0] err_cid,
  input wire logic [1:0] refresh_mode,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic readout_active,
  output logic read_dbi_en,
  output logic array_rd_valid,
  output logic [1:0] array_rd_bank,
  output logic [1:0] array_rd_group,
  output logic [17:0] array_rd_addr
);
  typedef struct packed {
    drra_mr_t [`DRRA_NUM_MR-1:0] mr;
    drra_page_t page0;
    logic [`DRRA_DUE_W-1:0] now;
    drra_state_t st;
    logic [2:0] beat;
    logic pre;
    logic [`DRRA_DATA_W-1:0] data;
    logic bc4;
    logic serial;
    logic [7:0] dq;
    logic dq_oe;
    logic dqs;
    logic dqs_oe;
    logic active;
    logic rdbi;
    logic arr_valid;
    logic [1:0] arr_bank;
    logic [1:0] arr_group;
    logic [17:0] arr_addr;
  } drra_top_s_t;

  drra_top_s_t s_reg, s_next;
  logic fifo_in_ready, fifo_out_valid, fifo_pop, take_read;
  logic [`DRRA_ENTRY_W-1:0] push_entry, head_entry;
  drra_page_t page_regs;
  logic [1:0] cur_fmt, cur_page;
  logic bc4_cmd, serial_eff;
  logic [`DRRA_DUE_W-1:0] head_due, due_gap;
  logic [`DRRA_DATA_W-1:0] burst_img;

  // lay the addressed page out as eight beats on eight lanes
  function automatic logic [`DRRA_DATA_W-1:0] build_burst(
    input drra_page_t regs,
    input logic [1:0] sel,
    input logic [1:0] fmt,
    input logic upper
  );
    logic [`DRRA_DATA_W-1:0] img;
    logic [2:0] ub;
    logic [1:0] loc;
    img = '0;
    for (int b = 0; b < `DRRA_BEATS; b++) begin
      ub = 3'(b) + (upper ? 3'h4 : 3'h0);
      for (int l = 0; l < `DRRA_LANES; l++) begin
        loc = sel + 2'(l);
        case (fmt)
          `DRRA_FMT_PARALLEL: img[b*8+l] = regs[0][3'h7 - 3'(l)];
          `DRRA_FMT_STAGGER: img[b*8+l] = regs[loc][3'h7 - ub];
          default: img[b*8+l] = regs[sel][3'h7 - ub];
        endcase
      end
    end
    return img;
  endfunction

  // current mode settings and the readable page contents
  always_comb begin
    cur_fmt = s_reg.mr[`DRRA_MR3][12:11];
    cur_page = s_reg.mr[`DRRA_MR3][1:0];
    // pages 1-3 and the reserved format fall back to serial
    serial_eff = (cur_page != `DRRA_PAGE0) || (cur_fmt == 2'h3);
    case (cur_page)
      2'h1: begin
        page_regs[0] = err_frame[7:0];
        page_regs[1] = err_frame[15:8];
        page_regs[2] = err_frame[23:16];
        page_regs[3] = {err_crc, err_parity,
                        s_reg.mr[`DRRA_MR5][2:0], err_cid};
      end
      2'h2: begin
        page_regs[0] = {HARD_REPAIR_SUPPORT, SOFT_REPAIR_SUPPORT, 1'b0,
                        refresh_mode, 1'b0,
                        s_reg.mr[`DRRA_MR2][10:9]};
        page_regs[1] = {s_reg.mr[`DRRA_MR6][6], s_reg.mr[`DRRA_MR6][5:0],
                        s_reg.mr[`DRRA_MR3][`DRRA_MR3_GEAR_BIT]};
        page_regs[2] = {s_reg.mr[`DRRA_MR0][6:4], s_reg.mr[`DRRA_MR0][2],
                        s_reg.mr[`DRRA_MR0][12], s_reg.mr[`DRRA_MR2][5:3]};
        page_regs[3] = {s_reg.mr[`DRRA_MR1][10:8], s_reg.mr[`DRRA_MR5][8:6],
                        s_reg.mr[`DRRA_MR1][2:1]};
      end
      2'h3: begin
        page_regs[0] = 8'h00;
        page_regs[1] = 8'h00;
        page_regs[2] = 8'h00;
        page_regs[3] = {SELFTEST_REPAIR_SUPPORT, 1'b0, REPAIR_TRANSPARENCY,
                        ACTIVATION_COUNT_LIMIT};
      end
      default: page_regs = s_reg.page0;
    endcase
  end

  // burst kind and the fifo entry for an accepted readout read
  always_comb begin
    case (s_reg.mr[`DRRA_MR0][1:0])
      `DRRA_BL_FIXED4: bc4_cmd = 1'b1;
      `DRRA_BL_OTF: bc4_cmd = !cmd_addr[12]; // host keeps A12 high
      default: bc4_cmd = 1'b0;
    endcase
    // A1:A0, A10 and the group bits play no part here
    burst_img = build_burst(page_regs, cmd_ba,
                            serial_eff ? `DRRA_FMT_SERIAL : cur_fmt,
                            bc4_cmd && cmd_addr[2]);
    take_read = cmd_valid && cmd_read && s_reg.active && fifo_in_ready;
    push_entry = {s_reg.now + `DRRA_DUE_W'(read_latency),
                  serial_eff || (cur_fmt == `DRRA_FMT_SERIAL),
                  bc4_cmd, burst_img};
    head_due = head_entry[`DRRA_ENTRY_W-1 -: `DRRA_DUE_W];
    // wrap-safe: start once the gap has reached or passed zero
    due_gap = head_due - s_reg.now - `DRRA_DUE_W'(s_reg.pre);
  end

  assign fifo_pop = (s_reg.st == ST_IDLE) && fifo_out_valid &&
                    ((due_gap == '0) || due_gap[`DRRA_DUE_W-1]);

  drra_fifo #(
    .WIDTH(`DRRA_ENTRY_W),
    .DEPTH(`DRRA_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(take_read),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(head_entry)
  );

  // command decode, shadow registers and the burst sequencer
  always_comb begin
    s_next = s_reg;
    s_next.now = s_reg.now + 1'b1;
    s_next.arr_valid = 1'b0;
    if (cmd_valid && cmd_mrs && (cmd_mr_sel < `DRRA_NUM_MR)) begin
      s_next.mr[cmd_mr_sel] = cmd_addr;
    end
    // only page 0 takes writes; the rest is read-only
    if (cmd_valid && cmd_write && s_reg.active &&
        (cur_page == `DRRA_PAGE0)) begin
      s_next.page0[cmd_ba] = cmd_addr[7:0];
    end
    // with readout off the read goes to the array untouched
    if (cmd_valid && cmd_read && !s_reg.active) begin
      s_next.arr_valid = 1'b1;
      s_next.arr_bank = cmd_ba;
      s_next.arr_group = cmd_bg;
      s_next.arr_addr = cmd_addr;
    end
    s_next.active = s_next.mr[`DRRA_MR3][`DRRA_MR3_EN_BIT];
    s_next.rdbi = s_next.mr[`DRRA_MR5][`DRRA_MR5_RDBI_BIT] &&
                  !s_next.active;
    s_next.pre = s_next.mr[`DRRA_MR4][`DRRA_MR4_RPRE_BIT];
    case (s_reg.st)
      ST_IDLE: begin
        s_next.dq = 8'h00;
        s_next.dq_oe = 1'b0;
        s_next.dqs = 1'b0;
        s_next.dqs_oe = 1'b0;
        if (fifo_pop) begin
          s_next.data = head_entry[`DRRA_DATA_W-1:0];
          s_next.bc4 = head_entry[`DRRA_DATA_W];
          s_next.serial = head_entry[`DRRA_DATA_W+1];
          s_next.beat = 3'h0;
          s_next.dqs_oe = 1'b1; // preamble, strobe held low
          s_next.st = s_reg.pre ? ST_PRE : ST_BURST;
        end
      end
      ST_PRE: begin
        s_next.dqs_oe = 1'b1;
        s_next.dqs = 1'b0;
        s_next.st = ST_BURST;
      end
      ST_BURST: begin
        s_next.dq = s_reg.data[s_reg.beat*8 +: 8];
        s_next.dq_oe = !(s_reg.bc4 && s_reg.beat[2]);
        s_next.dqs = !s_reg.beat[0];
        s_next.dqs_oe = s_next.dq_oe;
        if (!s_next.dq_oe) begin
          s_next.dq = 8'h00;
          s_next.dqs = 1'b0;
        end
        s_next.beat = s_reg.beat + 1'b1;
        if (s_reg.beat == 3'(`DRRA_BEATS - 1)) begin
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // reset stands for initialization: page 0 back to its patterns
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.page0[0] <= `DRRA_P0_REG0_RST;
      s_reg.page0[1] <= `DRRA_P0_REG1_RST;
      s_reg.page0[2] <= `DRRA_P0_REG2_RST;
      s_reg.page0[3] <= `DRRA_P0_REG3_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cmd_ready = fifo_in_ready;
  assign dq_out = s_reg.dq;
  assign dq_oe = s_reg.dq_oe;
  assign dqs_out = s_reg.dqs;
  assign dqs_oe = s_reg.dqs_oe;
  assign readout_active = s_reg.active;
  assign read_dbi_en = s_reg.rdbi;
  assign array_rd_valid = s_reg.arr_valid;
  assign array_rd_bank = s_reg.arr_bank;
  assign array_rd_group = s_reg.arr_group;
  assign array_rd_addr = s_reg.arr_addr;

  // checks on the driven pins and the state behind them
  a_dbi_held_off: assert property (@(posedge core_clk) disable iff (reset)
    readout_active |-> !read_dbi_en)
    else $error("read inversion active in readout mode");
  a_page0_default: assert property (@(posedge core_clk) disable iff (reset)
    $past(reset) |-> (s_reg.page0 == {8'h00, 8'h0F, 8'h33, 8'h55}))
    else $error("page 0 not at default patterns after reset");
  a_bl8_length: assert property (@(posedge core_clk) disable iff (reset)
    ($rose(dq_oe) && !s_reg.bc4) |-> dq_oe [*8] ##1 !dq_oe)
    else $error("eight-beat burst has wrong length");
  a_bc4_tristate: assert property (@(posedge core_clk) disable iff (reset)
    ($rose(dq_oe) && s_reg.bc4) |-> dq_oe [*4] ##1 !dq_oe [*4])
    else $error("chop four burst not tristated after four beats");
  a_strobe_toggle: assert property (@(posedge core_clk) disable iff (reset)
    (dq_oe && $past(dq_oe)) |-> (dqs_out != $past(dqs_out)))
    else $error("strobe did not toggle with data");
  a_preamble_lead: assert property (@(posedge core_clk) disable iff (reset)
    $rose(dq_oe) |-> ($past(dqs_oe) && !$past(dqs_out)))
    else $error("data burst without strobe preamble");
  a_serial_lanes: assert property (@(posedge core_clk) disable iff (reset)
    (dq_oe && s_reg.serial) |-> (dq_out == {8{dq_out[0]}}))
    else $error("serial format lanes differ");
  a_array_pass: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd_read && !readout_active) |=>
      (array_rd_valid && array_rd_bank == $past(cmd_ba)))
    else $error("array read not forwarded");
  a_no_array_read: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd_read && readout_active) |=> !array_rd_valid)
    else $error("readout read leaked to the array");
  a_latency_start: assert property (@(posedge core_clk) disable iff (reset)
    (take_read && !fifo_out_valid && s_reg.st == ST_IDLE &&
     read_latency == 7'h08 && !s_reg.pre &&
     !(cmd_valid && cmd_mrs)) |-> ##[8:9] dqs_oe)
    else $error("burst did not start at read latency");

  c_bl8_burst: cover property (@(posedge core_clk) disable iff (reset)
    $rose(dq_oe) && !s_reg.bc4);
  c_bc4_burst: cover property (@(posedge core_clk) disable iff (reset)
    $rose(dq_oe) && s_reg.bc4);
  c_stagger_read: cover property (@(posedge core_clk) disable iff (reset)
    take_read && cur_fmt == `DRRA_FMT_STAGGER && !serial_eff);
  c_fifo_full: cover property (@(posedge core_clk) disable iff (reset)
    s_reg.active && !cmd_ready);
endmodule
`default_nettype wire

// ### pkg/drra_params.svh
// constants for the dram readout register access block
`ifndef DRRA_PARAMS_SVH
`define DRRA_PARAMS_SVH
`define DRRA_NUM_MR 7
`define DRRA_MR_W 18
`define DRRA_MR0 3'h0
`define DRRA_MR1 3'h1
`define DRRA_MR2 3'h2
`define DRRA_MR3 3'h3
`define DRRA_MR4 3'h4
`define DRRA_MR5 3'h5
`define DRRA_MR6 3'h6
`define DRRA_MR3_EN_BIT 2
`define DRRA_MR3_GEAR_BIT 3
`define DRRA_MR4_RPRE_BIT 11
`define DRRA_MR5_RDBI_BIT 12
`define DRRA_BL_FIXED8 2'h0
`define DRRA_BL_OTF 2'h1
`define DRRA_BL_FIXED4 2'h2
`define DRRA_FMT_SERIAL 2'h0
`define DRRA_FMT_PARALLEL 2'h1
`define DRRA_FMT_STAGGER 2'h2
`define DRRA_PAGE0 2'h0
`define DRRA_P0_REG0_RST 8'h55
`define DRRA_P0_REG1_RST 8'h33
`define DRRA_P0_REG2_RST 8'h0F
`define DRRA_P0_REG3_RST 8'h00
`define DRRA_BEATS 8
`define DRRA_LANES 8
`define DRRA_DATA_W 64
`define DRRA_DUE_W 8
`define DRRA_ENTRY_W 74
`define DRRA_FIFO_DEPTH 16
`endif

// ### pkg/drra_pkg.sv
// types shared by the dram readout register access block
`default_nettype none
package drra_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_BURST} drra_state_t;
  typedef logic [7:0] drra_byte_t;
  typedef drra_byte_t [3:0] drra_page_t;
  typedef logic [17:0] drra_mr_t;
endpackage
`default_nettype wire

// ### verif/drra_ctrl_model.sv
// controller-side model that drives the readout block command port
`timescale 1ns/1ps
`default_nettype none
module drra_ctrl_model #(
  parameter int MOD_CYC = 4
) (
  input wire logic core_clk,
  output logic cmd_valid,
  output logic cmd_mrs,
  output logic cmd_read,
  output logic cmd_write,
  output logic [2:0] cmd_mr_sel,
  output logic [17:0] cmd_addr,
  output logic [1:0] cmd_ba,
  output logic [1:0] cmd_bg
);
  initial begin
    {cmd_valid, cmd_mrs, cmd_read, cmd_write} = 4'h0;
    cmd_mr_sel = 3'h0;
    cmd_addr = 18'h00000;
    cmd_ba = 2'h0;
    cmd_bg = 2'h0;
  end

  // drive one command at a falling edge and hold it across the next rise
  task automatic issue(input logic [3:0] kind, input logic [2:0] sel,
                       input logic [17:0] a, input logic [1:0] ba);
    {cmd_valid, cmd_mrs, cmd_read, cmd_write} = kind;
    cmd_mr_sel = sel;
    cmd_addr = a;
    cmd_ba = ba;
    cmd_bg = ~ba;
    @(negedge core_clk);
  endtask

  // released lines carry junk so a stale value is never mistaken for a hit
  task automatic release_bus();
    {cmd_valid, cmd_mrs, cmd_read, cmd_write} = 4'h0;
    cmd_addr = ~cmd_addr;
    cmd_ba = ~cmd_ba;
  endtask

  // mode write, then the settle time before anything else goes out
  task automatic mrs(input logic [2:0] sel, input logic [17:0] v);
    issue(4'hC, sel, v, 2'h0);
    release_bus();
    repeat (MOD_CYC) @(negedge core_clk);
  endtask

  // low two bits stay 00, a10 and a9 are junk the device must ignore
  task automatic rd(input logic [1:0] ba, input logic a2, input logic a12);
    logic [17:0] addr;
    addr = {5'h0, a12, 9'h0C0, a2, 2'h0};
    issue(4'hA, 3'h0, addr, ba);
    release_bus();
  endtask

  task automatic wr(input logic [1:0] ba, input logic [7:0] d);
    issue(4'h9, 3'h0, {10'h000, d}, ba);
    release_bus();
  endtask
endmodule
`default_nettype wire

// ### verif/tb_dram_readout_register_access.sv
// self-checking bench for the readout register access block
`timescale 1ns/1ps
`default_nettype none
module tb_dram_readout_register_access;
  import drra_pkg::*;
  typedef struct {
    logic [17:0] mr3;
    logic [1:0] ba;
    logic [63:0] exp;
  } drra_row_t;
  logic core_clk, reset, cmd_valid, cmd_ready, cmd_mrs, cmd_read, cmd_write;
  logic [2:0] cmd_mr_sel;
  logic [17:0] cmd_addr, array_rd_addr;
  logic [1:0] cmd_ba, cmd_bg, refresh_mode, array_rd_bank, array_rd_group;
  logic [6:0] read_latency;
  logic [23:0] err_frame;
  logic [7:0] dq_out;
  logic dq_oe, dqs_out, dqs_oe, readout_active, read_dbi_en, array_rd_valid;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int beats = 0;
  int acc;
  // serial, parallel, staggered, reserved format, then pages one and two
  drra_row_t rows [10] = '{
    '{18'h00004, 2'h0, 64'h00FF00FF00FF00FF},
    '{18'h00004, 2'h1, 64'h0000FFFF0000FFFF},
    '{18'h00004, 2'h2, 64'h00000000FFFFFFFF},
    '{18'h00004, 2'h3, 64'h0000000000000000},
    '{18'h00804, 2'h0, 64'hAAAAAAAAAAAAAAAA},
    '{18'h01004, 2'h0, 64'h0011223344556677},
    '{18'h01804, 2'h0, 64'h00FF00FF00FF00FF},
    '{18'h00005, 2'h0, 64'hFF00000000000000},
    '{18'h0000E, 2'h1, 64'hFFFF00FF00FF00FF},
    '{18'h0000E, 2'h0, 64'h000000FF00000000}};

  drra_ctrl_model i_ctrl (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_mrs(cmd_mrs), .cmd_read(cmd_read), .cmd_write(cmd_write),
    .cmd_mr_sel(cmd_mr_sel), .cmd_addr(cmd_addr), .cmd_ba(cmd_ba),
    .cmd_bg(cmd_bg));
  drra_readout i_dut (.core_clk(core_clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_mrs(cmd_mrs),
    .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_mr_sel(cmd_mr_sel),
    .cmd_addr(cmd_addr), .cmd_ba(cmd_ba), .cmd_bg(cmd_bg),
    .read_latency(read_latency), .err_frame(err_frame), .err_crc(1'b0),
    .err_parity(1'b0), .err_cid(3'h0), .refresh_mode(refresh_mode),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .readout_active(readout_active), .read_dbi_en(read_dbi_en),
    .array_rd_valid(array_rd_valid), .array_rd_bank(array_rd_bank),
    .array_rd_group(array_rd_group), .array_rd_addr(array_rd_addr));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // hang guard: a few thousand cycles covers every test with margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      stop_test();
    end
  end

  always @(negedge core_clk) begin
    if (dq_oe === 1'b1) beats++;
  end

  task automatic check(input logic [63:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // entered at the fall after the read was taken; n beats then idle slots
  task automatic burst(input logic [63:0] exp, input int n);
    logic [63:0] got;
    logic pre;
    int k;
    logic [2:0] want;
    got = 64'h0;
    pre = 1'b0;
    want = 3'h0;
    // k counts falls waited: first beat is RL + 1 edges after the command
    k = 0;
    while (dq_oe !== 1'b1 && k < 100) begin
      pre = (dqs_oe === 1'b1) && (dqs_out === 1'b0);
      @(negedge core_clk);
      k++;
    end
    check(64'(k), 64'(read_latency) + 64'h1, "latency");
    check(64'(pre), 64'h1, "preamble");
    for (int b = 0; b < 8; b++) begin
      if (b < n) got[63-8*b -: 8] = dq_out;
      want = (b < n) ? {2'b11, ~b[0]} : 3'h0;
      check({dq_oe, dqs_oe, dqs_out}, want, "beat");
      @(negedge core_clk);
    end
    check(got, exp, "burst data");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    read_latency = 7'd8;
    err_frame = 24'h000080;
    refresh_mode = 2'b10;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    check({cmd_ready, readout_active, dq_oe, dqs_oe, array_rd_valid},
          5'h10, "reset");
    i_ctrl.mrs(3'h5, 18'h01000);
    check(read_dbi_en, 1'b1, "dbi off mode");
    i_ctrl.mrs(3'h6, 18'h0006A);
    foreach (rows[i]) begin
      i_ctrl.mrs(3'h3, rows[i].mr3);
      check({readout_active, read_dbi_en}, 2'b10, "mode");
      i_ctrl.rd(rows[i].ba, 1'b0, 1'b0);
      burst(rows[i].exp, 8);
      $display("row %0d done", i);
    end
    // chop four both halves, then on-the-fly select with a12 high
    i_ctrl.mrs(3'h0, 18'h00002);
    i_ctrl.mrs(3'h3, 18'h00004);
    i_ctrl.rd(2'h0, 1'b1, 1'b0);
    burst(64'h00FF00FF00000000, 4);
    i_ctrl.rd(2'h1, 1'b0, 1'b0);
    burst(64'h0000FFFF00000000, 4);
    i_ctrl.mrs(3'h0, 18'h00001);
    i_ctrl.rd(2'h0, 1'b0, 1'b1);
    burst(64'h00FF00FF00FF00FF, 8);
    i_ctrl.mrs(3'h0, 18'h00000);
    // two-cycle preamble: the strobe leads earlier, data keeps its beat
    i_ctrl.mrs(3'h4, 18'h00800);
    i_ctrl.rd(2'h1, 1'b0, 1'b0);
    burst(64'h0000FFFF0000FFFF, 8);
    i_ctrl.mrs(3'h4, 18'h00000);
    $display("burst length test done");
    // rewrite page 0, then reinitialize and expect the default back
    i_ctrl.wr(2'h2, 8'h81);
    i_ctrl.rd(2'h2, 1'b0, 1'b0);
    burst(64'hFF000000000000FF, 8);
    reset = 1'b1;
    @(negedge core_clk);
    reset = 1'b0;
    check({cmd_ready, readout_active, dq_oe, dqs_oe, array_rd_valid},
          5'h10, "reset again");
    // inversion bit set while readout is off must not reach readout data
    i_ctrl.mrs(3'h5, 18'h01000);
    i_ctrl.mrs(3'h3, 18'h00004);
    check({readout_active, read_dbi_en}, 2'b10, "mode again");
    i_ctrl.rd(2'h2, 1'b0, 1'b0);
    burst(64'h00000000FFFFFFFF, 8);
    $display("page rewrite test done");
    // reads at the short four-cycle spacing still outrun the bursts
    beats = 0;
    acc = 0;
    for (int i = 0; i < 40; i++) begin
      acc += (cmd_ready === 1'b1) ? 1 : 0;
      i_ctrl.rd(2'h0, 1'b0, 1'b0);
      repeat (3) @(negedge core_clk);
    end
    repeat (300) @(negedge core_clk);
    check(64'(acc < 40), 64'h1, "queue refusal");
    check(64'(beats), 64'(8 * acc), "queued beats");
    check(cmd_ready, 1'b1, "queue drained");
    $display("queue test done");
    // readout off: reads reach the array with their address
    i_ctrl.mrs(3'h3, 18'h00000);
    check({readout_active, read_dbi_en}, 2'b01, "exit");
    i_ctrl.rd(2'h2, 1'b0, 1'b0);
    for (int k = 0; k < 3 && array_rd_valid !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    check(array_rd_valid, 1'b1, "array read");
    check(array_rd_addr, 18'h00600, "array addr");
    check({array_rd_bank, array_rd_group}, 4'h9, "bank group");
    check(dq_oe, 1'b0, "no readout");
    $display("array read test done");
    stop_test();
  end
endmodule
`default_nettype wire
